// >>> pkg/ccd_mem_pkg.sv
/*
 Constants shared by the serial charge-coupled memory model and its controller.
 Assumes a single 40 MHz clock, a synchronous active-high reset on both ends.
*/
package ccd_mem_pkg;
    localparam int NUM_REGS     = 64;
    localparam int REG_BITS     = 256;
    localparam int ADDR_W       = 6;
    localparam int POS_W        = 8;
    localparam int CLK_NS       = 25;
    // Least half period of a clock phase, in ns
    localparam int HALF_PER_NS  = 750;
    localparam int HALF_PER_CYC = (HALF_PER_NS + CLK_NS - 1) / CLK_NS;
    // Longest interval between shifts, in ns
    localparam int REFRESH_NS   = 10000;
    localparam int REFRESH_CYC  = REFRESH_NS / CLK_NS;
    localparam int MAX_ACCESS   = 16;
    localparam int WARMUP_SHIFTS = 4000;
    // Access cycle: strobe high length and write pulse length, in ns
    localparam int STROBE_NS    = 300;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPULSE_NS    = 100;
    localparam int WPULSE_CYC   = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage : ccd_mem_pkg

// >>> pkg/ccd_mem_if.sv
/*
 Pin bundle between the memory and its controller.
 Assumes both ends sit on the same clock; data out is resolved here from its enable.
*/
`timescale 1ns/10ps
interface ccd_mem_if;
    logic [3:0] phase;      // Four clock phases, bit 0 = first phase
    logic [5:0] regAddr;    // Register address
    logic       cycStrobe;  // Access cycle strobe, active high
    logic       wrStrobe;   // Write strobe, active high
    logic       ioSel;      // I/O select, active high
    logic       dataIn;     // Data into the memory
    logic       dataOut;    // Data out of the memory
    logic       dataOutOe;  // Output enable, low while driving
    wire        dataLine = dataOutOe ? 1'b1 : dataOut; // Pull-up termination

    modport mem  (input phase, regAddr, cycStrobe, wrStrobe, ioSel, dataIn,
                  output dataOut, dataOutOe);
    modport ctrl (output phase, regAddr, cycStrobe, wrStrobe, ioSel, dataIn,
                  input dataLine);
endinterface : ccd_mem_if

// >>> design/ccd_mem_device.sv
/*
 Behavioural model of the 64 x 256 recirculating shift memory.
 Assumes the controller keeps all phase and strobe timing; pins arrive asynchronously.
*/
`timescale 1ns/10ps
module ccd_mem_device (
    input  wire logic clk,     // 40 MHz clock
    input  wire logic sys_rst, // Synchronous reset, active high
    ccd_mem_if.mem    pins     // Link to controller
);
    import ccd_mem_pkg::*;

    logic [REG_BITS-1:0] store [NUM_REGS];
    logic [5:0] s1, s2;       // Synchronised phase2/4, strobe, we, sel, din, spare
    logic [ADDR_W-1:0] a1, a2;
    logic       ph2Prev_q, ph2Prev_d;
    logic [POS_W-1:0] pos_q, pos_d;
    logic       wrPrev_q, wrPrev_d;
    logic       dOut_q, dOut_d, oe_q, oe_d;
    logic       shiftNow, wrRise;

    // Two-stage synchronisers on all pins except phases 1 and 3, which are not sampled
    always_ff @(posedge clk) begin
        s1 <= {pins.phase[1] | pins.phase[3], pins.cycStrobe, pins.wrStrobe, pins.ioSel, pins.dataIn, 1'b0};
        s2 <= s1;
        a1 <= pins.regAddr;
        a2 <= a1;
    end

    // Shift on a rising edge of phase 2 or 4; completes before the next phase-1/3 fall
    assign shiftNow = s2[5] & ~ph2Prev_q;
    assign wrRise   = s2[4] & s2[3] & ~wrPrev_q;

    always_comb begin
        ph2Prev_d = s2[5];
        wrPrev_d  = s2[4] & s2[3];
        pos_d     = shiftNow ? pos_q + 1'b1 : pos_q;
        oe_d      = ~(s2[4] & s2[2]);
        dOut_d    = store[a2][pos_q];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ph2Prev_q <= 1'b0;
            wrPrev_q  <= 1'b0;
            pos_q     <= '0;
            oe_q      <= 1'b1;
            dOut_q    <= 1'b0;
        end else begin
            ph2Prev_q <= ph2Prev_d;
            wrPrev_q  <= wrPrev_d;
            pos_q     <= pos_d;
            oe_q      <= oe_d;
            dOut_q    <= dOut_d;
        end
    end

    // Exposed bit rotates by pointer, so recirculation costs no data motion
    always_ff @(posedge clk) begin
        if (wrRise && s2[2] && !shiftNow) begin
            store[a2][pos_q] <= s2[1];
        end
    end

    assign pins.dataOut   = dOut_q;
    assign pins.dataOutOe = oe_q;
endmodule : ccd_mem_device

// >>> design/ccd_mem_ctrl.sv
/*
 Controller end: generates four-phase shift clocks and framed access cycles.
 Assumes one clock with the memory; user requests are same-domain.
*/
// Notes on behaviour
// - Memory is 64 registers of 256 bits.
// - Six-bit address picks one register.
// - Any mix of accesses between shifts.
// - Shift at least every ten microseconds.
// - Shift ends on phase 1/3 fall.
// - Access only between phase1 fall and phase2 rise; accesses here run in PH2, after the phase2 rise, while phase 2 is high.
// - At most 16 accesses between shifts.
// - Cycle strobe frames every access.
// - Write low throughout means read.
// - Write pulse high stores input bit.
// - I/O select gates data only under strobe.
// - Output undriven while strobe low.
// - Half period no shorter than 750 ns.
// - Phase 2/4 rise shifts all registers.
// - Exposed bits move on, next exposed.
// - No access during a shift.
// - 4000 shifts before the first access.
`timescale 1ns/10ps
module ccd_mem_ctrl #(
    parameter int WARMUP = ccd_mem_pkg::WARMUP_SHIFTS // Shorten in simulation
) (
    input  wire logic              clk,     // 40 MHz clock
    input  wire logic              sys_rst, // Synchronous reset, active high
    ccd_mem_if.ctrl                pins,    // Link to memory
    input  wire logic              reqValid,// Access request
    input  wire logic              reqWrite,// 1 write, 0 read
    input  wire logic [ccd_mem_pkg::ADDR_W-1:0] reqAddr, // Register address
    input  wire logic              reqData, // Write data
    output logic                   reqReady,// Request taken this cycle
    output logic                   rdValid, // Read data pulse
    output logic                   rdData,  // Read data
    output logic                   warm     // Warm-up done
);
    import ccd_mem_pkg::*;

    typedef enum {PH1, PH2, PH3, PH4} phase_e;
    typedef enum {IDLE, STRB, WPUL, TAIL} acc_e;

    phase_e ph_q, ph_d;
    acc_e   acc_q, acc_d;
    logic [8:0]  halfCnt_q, halfCnt_d;
    logic [12:0] warm_q, warm_d;
    logic [4:0]  nAcc_q, nAcc_d;
    logic [4:0]  aCnt_q, aCnt_d;
    logic        wr_q, wr_d, din_q, din_d, rd_q, rd_d, rv_q, rv_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic        d1, d2;
    logic        halfDone, window;

    // Read data line passes two flops
    always_ff @(posedge clk) begin
        d1 <= pins.dataLine;
        d2 <= d1;
    end

    assign halfDone = halfCnt_q == 9'(HALF_PER_CYC - 1);
    // Access window is the phase 2 gap after phase 1 fell, with room for a cycle
    assign window   = (ph_q == PH2) && (halfCnt_q < 9'(HALF_PER_CYC - STROBE_CYC - 2));
    assign reqReady = (acc_q == IDLE) && window && warm && (nAcc_q < 5'(MAX_ACCESS)) && reqValid;

    // Phase sequencer and access engine
    always_comb begin
        ph_d = ph_q;
        halfCnt_d = halfCnt_q + 9'd1;
        warm_d = warm_q;
        nAcc_d = nAcc_q;
        acc_d = acc_q;
        aCnt_d = aCnt_q + 5'd1;
        wr_d = wr_q;
        din_d = din_q;
        addr_d = addr_q;
        rd_d = rd_q;
        rv_d = 1'b0;
        if (halfDone) begin
            halfCnt_d = '0;
            unique case (ph_q)
                PH1: ph_d = PH2;
                PH2: ph_d = PH3;
                PH3: ph_d = PH4;
                PH4: ph_d = PH1;
            endcase
            if (ph_q == PH1 || ph_q == PH3) begin
                nAcc_d = '0;
                if (warm_q != 13'(WARMUP)) warm_d = warm_q + 13'd1;
            end
        end
        unique case (acc_q)
            IDLE: begin
                aCnt_d = '0;
                if (reqReady) begin
                    acc_d = STRB;
                    addr_d = reqAddr;
                    din_d = reqData;
                    rd_d = ~reqWrite;
                    nAcc_d = nAcc_q + 5'd1;
                end
            end
            STRB: if (aCnt_q == 5'(STROBE_CYC - WPULSE_CYC - 1)) begin
                if (!rd_q) begin
                    acc_d = WPUL;
                    wr_d = 1'b1;
                    aCnt_d = '0;
                end else if (aCnt_q == 5'(STROBE_CYC - 1)) begin
                    acc_d = TAIL;
                end
            end else if (rd_q && aCnt_q == 5'(STROBE_CYC - 1)) begin
                acc_d = TAIL;
                rv_d = 1'b1;
            end
            WPUL: if (aCnt_q == 5'(WPULSE_CYC - 1)) begin
                wr_d = 1'b0;
                acc_d = TAIL;
            end
            TAIL: acc_d = IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ph_q <= PH1;
            acc_q <= IDLE;
            halfCnt_q <= '0;
            warm_q <= '0;
            nAcc_q <= '0;
            aCnt_q <= '0;
            wr_q <= 1'b0;
            din_q <= 1'b0;
            rd_q <= 1'b0;
            rv_q <= 1'b0;
            addr_q <= '0;
            rdData <= 1'b0;
        end else begin
            ph_q <= ph_d;
            acc_q <= acc_d;
            halfCnt_q <= halfCnt_d;
            warm_q <= warm_d;
            nAcc_q <= nAcc_d;
            aCnt_q <= aCnt_d;
            wr_q <= wr_d;
            din_q <= din_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
            addr_q <= addr_d;
            if (rv_d) rdData <= d2;
        end
    end

    // Phases are one-hot with phase 2 high while in PH2 etc.
    assign pins.phase     = {ph_q == PH4, ph_q == PH3, ph_q == PH2, ph_q == PH1};
    assign pins.regAddr   = addr_q;
    assign pins.cycStrobe = (acc_q == STRB) || (acc_q == WPUL);
    assign pins.wrStrobe  = wr_q;
    assign pins.ioSel     = pins.cycStrobe;
    assign pins.dataIn    = din_q;
    assign rdValid = rv_q;
    assign warm = warm_q == 13'(WARMUP);
endmodule : ccd_mem_ctrl

// >>> verification/ccd_mem_props.sv
/*
 Checker on the pins between controller and memory.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module ccd_mem_props (
    input wire logic       clk,       // Clock
    input wire logic       sys_rst,   // Reset
    input wire logic [3:0] phase,     // Shift phases
    input wire logic [5:0] regAddr,   // Register address
    input wire logic       cycStrobe, // Cycle strobe
    input wire logic       wrStrobe,  // Write strobe
    input wire logic       ioSel,     // I/O select
    input wire logic       dataOutOe  // Low while driving
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] prev_q;
    logic       strb_q;
    int         acc_q;
    int         acc_d;
    logic [8:0] halfLen_q;
    // Cycles since the last phase change, to bound the half period from below
    always_ff @(posedge clk) begin
        if (sys_rst) halfLen_q <= '0;
        else halfLen_q <= (phase != prev_q) ? 9'h0 : halfLen_q + 9'h1;
    end
    // Strobes since the last shift; cleared on a phase 2 or 4 rise
    always_comb begin
        acc_d = ((phase & ~prev_q & 4'ha) != 4'h0) ? 0 : acc_q + int'(cycStrobe && !strb_q);
    end
    always_ff @(posedge clk) begin
        prev_q <= phase;
        strb_q <= cycStrobe;
        acc_q  <= sys_rst ? 0 : acc_d;
    end
    // Device output lags the strobe by a few flops
    sequence readFrame;
        $rose(cycStrobe) ##0 (ioSel && !wrStrobe)[*6];
    endsequence
    sequence wrPulse;
        wrStrobe[*4] ##1 !wrStrobe;
    endsequence
    chk_idle_released: assert property (!cycStrobe[*5] |-> dataOutOe)
        else $error("data driven outside a cycle");
    chk_read_drives: assert property (readFrame |-> ##[0:4] !dataOutOe)
        else $error("read cycle without data drive");
    chk_write_pulse: assert property ($rose(wrStrobe) |-> wrPulse)
        else $error("write pulse length wrong");
    chk_write_framed: assert property (wrStrobe |-> cycStrobe)
        else $error("write outside a cycle");
    chk_strobe_frame: assert property ($rose(cycStrobe) |-> cycStrobe[*8] ##[1:32] !cycStrobe)
        else $error("cycle strobe length wrong");
    chk_no_shift: assert property (cycStrobe |-> $stable(phase))
        else $error("phase moved inside a cycle");
    chk_addr_hold: assert property (cycStrobe && $past(cycStrobe) |-> $stable(regAddr) && $stable(ioSel))
        else $error("address moved inside a cycle");
    chk_access_cap: assert property (acc_q <= 16)
        else $error("too many accesses between shifts");
    chk_phase_onehot: assert property ($onehot(phase))
        else $error("phases not one-hot");
    chk_shift_rate: assert property ($changed(phase) |-> ##[1:400] $changed(phase))
        else $error("shift interval too long");
    chk_access_window: assert property ($rose(cycStrobe) |-> phase == 4'h2)
        else $error("access outside the phase 2 window");
    chk_half_period: assert property ($changed(phase) |-> halfLen_q >= 9'(ccd_mem_pkg::HALF_PER_CYC - 1))
        else $error("phase half period too short");
endmodule : ccd_mem_props

// >>> verification/ccd_shift_memory_access_test.sv
/*
 Bench joining controller and memory through the pin bundle.
 Assumes a short warm-up count; expected bits come from a shadow array.
*/
`timescale 1ns/10ps
module ccd_shift_memory_access_test;
    import ccd_mem_pkg::*;
    logic              clk, sys_rst, reqValid, reqWrite, reqData;
    logic              reqReady, rdValid, rdData, warm;
    logic [ADDR_W-1:0] reqAddr;
    logic [3:0]        prevPh;
    logic [1:0]        memBit[NUM_REGS][REG_BITS]; // Known flag, value
    logic [1:0]        expQ[$];
    logic [1:0]        expE;
    int                bad_count, cmp_count, seed, pos, r;
    ccd_mem_if pins ();
    ccd_mem_device u_ccd_mem_device (.clk(clk), .sys_rst(sys_rst), .pins(pins.mem));
    ccd_mem_ctrl #(.WARMUP(4)) u_ccd_mem_ctrl (.clk(clk), .sys_rst(sys_rst), .pins(pins.ctrl),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
        .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .warm(warm));
    ccd_mem_props u_props (.clk(clk), .sys_rst(sys_rst), .phase(pins.phase), .regAddr(pins.regAddr),
        .cycStrobe(pins.cycStrobe), .wrStrobe(pins.wrStrobe), .ioSel(pins.ioSel),
        .dataOutOe(pins.dataOutOe));
    task automatic check(input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // Request held until taken; the shadow array notes what the bit must hold
    task automatic do_op(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
        int p;
        int n;
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr  <= a;
        reqData  <= d;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (reqReady !== 1'b1 && n < 400);
        if (n >= 400) bad_count++;
        check(warm, 1'b1);
        p = (pos + int'((pins.phase & ~prevPh & 4'ha) != 4'h0)) % REG_BITS;
        if (wr) memBit[a][p] = {1'b1, d};
        else expQ.push_back(memBit[a][p]);
        @(posedge clk);
        reqValid <= 1'b0;
    endtask : do_op
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Bit position follows each phase 2 or 4 rise, wrapping after a full lap
    always @(posedge clk) begin
        prevPh <= pins.phase;
        if (sys_rst) pos <= 0;
        else if ((pins.phase & ~prevPh & 4'ha) != 4'h0) pos <= (pos + 1) % REG_BITS;
    end
    // Each read answer takes the oldest note; unknown bits are skipped
    always @(negedge clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) check(1'b1, 1'b0);
            else begin
                expE = expQ.pop_front();
                if (expE[1]) check(rdData, expE[0]);
            end
        end
    end
    // Hang guard, well beyond the traffic's length
    initial begin
        #(80000 * 25);
        bad_count++;
        complete_run();
    end
    initial begin
        sys_rst = 1'b1;
        {reqValid, reqWrite, reqData} = 3'h0;
        reqAddr = '0;
        {bad_count, cmp_count} = 0;
        seed = 32'he675b53f;
        foreach (memBit[i, j]) memBit[i][j] = 2'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        // Mixed traffic, mostly on four addresses so bits are revisited after a lap
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            reqAddr <= reqAddr;
            if (r[10]) begin
                do_op(1'b1, r[9] ? r[5:0] : {4'h0, r[1:0]}, r[8]);
                do_op(1'b0, r[9] ? r[5:0] : {4'h0, r[1:0]}, 1'b0);
            end else do_op(r[6], r[9] ? r[5:0] : {4'h0, r[1:0]}, r[8]);
        end
        repeat (200) @(posedge clk);
        complete_run();
    end
endmodule : ccd_shift_memory_access_test
